// ===== chstm_core.sv
// Operation
// - Geometry command runs regardless of drive ready
// - Sectors from count, max head from nibble
// - Default geometry supported, others optional
// - Unsupported geometry aborts with abort bit
// - Unsupported geometry clears word 53 bit0
// - Media access fails ID-not-found while invalid
// - Words 1,3,6,61:60 never change
// - Word 55 equals max head plus one
// - Word 56 equals sectors per track
// - Word 54 is capped capacity quotient
// - Words 58:57 equal product 54*55*56
// - Success clears busy, drq, fault, error
// - Error completion sets error; fault only when fault input set
// - Device select bit shown in dev/head
// - Eject finishes, spins down, unlocks, ejects
// - Eject without media sets no_media
// - Unimplemented eject would abort
// - Abort when action cannot complete
// - Single media lock level only
// - Non-data protocol, no transfer phase
// - Lock sets locked state, no error
// - Change request while locked sets MEDIA_CHANGE_REQUEST
`timescale 1ns/1ps
`default_nettype none
module chstm_core (
    input  wire logic                         sys_clk_in,
    input  wire logic                         rstn_in,
    input  wire chstm_pkg::chstm_avl_req_type avl_req_in,
    output logic [31:0]                       avl_readdata_out,
    output logic                              avl_waitrequest_out,
    input  wire logic                         ready_in,
    input  wire logic                         media_present_in,
    input  wire logic                         change_button_in,
    input  wire logic                         fault_in,
    input  wire logic                         spun_down_in,
    output logic                              spindle_stop_out,
    output logic                              eject_out,
    output logic                              lock_out
);
    import chstm_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_DIVIDE, S_SPIN, S_EJECT, S_DONE} chstm_state_type;

    chstm_state_type  state_q, state_d;
    chstm_status_type status_q;
    chstm_error_type  err_q, res_q, res_d;
    logic [4:0]  meta_q, sync_q, hist_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [7:0]  feat_q, seccnt_q, secnum_q, cyllo_q, cylhi_q, devhead_q, cmd_q;
    logic        lock_q, mcr_q, geom_ok_q;
    logic [15:0] w54_q, w55_q, w56_q;
    logic [31:0] w5857_q;
    logic [12:0] rem_q;
    logic [23:0] quo_q;
    logic [12:0] divisor_q;
    logic [4:0]  div_cnt_q;

    // Pin inputs pass two flops; only sync_q and hist_q feed logic
    wire ready_s   = sync_q[4];
    wire media_s   = sync_q[3];
    wire button_s  = sync_q[2];
    wire fault_s   = sync_q[1];
    wire spun_s    = sync_q[0];
    wire ready_up  = ready_s & ~hist_q[4];
    wire ready_dn  = ~ready_s & hist_q[4];
    wire button_up = button_s & ~hist_q[2];

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            meta_q <= '0;
            sync_q <= '0;
            hist_q <= '0;
        end else begin
            meta_q <= {ready_in, media_present_in, change_button_in, fault_in, spun_down_in};
            sync_q <= meta_q;
            hist_q <= sync_q;
        end
    end

    // Avalon slave: one wait cycle, then the request completes
    wire req_any  = avl_req_in.read | avl_req_in.write;
    wire be_low   = avl_req_in.byteenable[0];
    wire wr_fire  = avl_req_in.write & ack_q & be_low;
    wire [7:0] wbyte = avl_req_in.writedata[7:0];
    wire busy     = status_q.busy;
    // Task-file writes while busy are dropped so inputs stay stable
    wire tf_wr    = wr_fire & ~busy;
    wire cmd_go   = tf_wr & (avl_req_in.address == OFS_COMMAND);

    assign avl_waitrequest_out = req_any & ~ack_q;

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_any & ~ack_q;
        end
    end

    // Read multiplexer; unmapped addresses read zero
    logic [31:0] rmux;
    always_comb begin
        rmux = '0;
        unique case (avl_req_in.address)
            OFS_ERROR:    rmux = {24'h00_0000, err_q};
            OFS_SECCNT:   rmux = {24'h00_0000, seccnt_q};
            OFS_SECNUM:   rmux = {24'h00_0000, secnum_q};
            OFS_CYL_LO:   rmux = {24'h00_0000, cyllo_q};
            OFS_CYL_HI:   rmux = {24'h00_0000, cylhi_q};
            OFS_DEVHEAD:  rmux = {24'h00_0000, devhead_q};
            OFS_STATUS:   rmux = {24'h00_0000, status_q};
            OFS_ID_W1:    rmux = {16'h0000, DEF_CYL};
            OFS_ID_W3:    rmux = {16'h0000, DEF_HEADS};
            OFS_ID_W6:    rmux = {16'h0000, DEF_SPT};
            OFS_ID_W53:   rmux = {31'h0000_0000, geom_ok_q};
            OFS_ID_W54:   rmux = {16'h0000, w54_q};
            OFS_ID_W55:   rmux = {16'h0000, w55_q};
            OFS_ID_W56:   rmux = {16'h0000, w56_q};
            OFS_ID_W5857: rmux = w5857_q;
            OFS_ID_W6160: rmux = CAPACITY_SECTORS;
            default:      rmux = '0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            rdata_q <= '0;
        end else if (avl_req_in.read & ~ack_q) begin
            rdata_q <= rmux;
        end
    end
    assign avl_readdata_out = rdata_q;

    // Task-file input registers, writable only while idle
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            feat_q    <= RST_BYTE;
            seccnt_q  <= RST_BYTE;
            secnum_q  <= RST_BYTE;
            cyllo_q   <= RST_BYTE;
            cylhi_q   <= RST_BYTE;
            devhead_q <= RST_BYTE;
            cmd_q     <= RST_BYTE;
        end else if (tf_wr) begin
            if (avl_req_in.address == OFS_FEATURE) feat_q <= wbyte;
            if (avl_req_in.address == OFS_SECCNT) seccnt_q <= wbyte;
            if (avl_req_in.address == OFS_SECNUM) secnum_q <= wbyte;
            if (avl_req_in.address == OFS_CYL_LO) cyllo_q <= wbyte;
            if (avl_req_in.address == OFS_CYL_HI) cylhi_q <= wbyte;
            if (avl_req_in.address == OFS_DEVHEAD) devhead_q <= wbyte;
            if (cmd_go) cmd_q <= wbyte;
        end
    end

    // Geometry decode from the task file
    wire [7:0]  new_spt   = seccnt_q;
    wire [4:0]  new_heads = {1'b0, devhead_q[HEAD_MSB:0]} + 5'h01;
    wire        spt_ok    = (new_spt != 8'h00) && (new_spt <= SPT_MAX);
    wire [12:0] divisor_n = 13'(new_heads * new_spt);
    wire [13:0] trial     = {rem_q, quo_q[23]} - {1'b0, divisor_q};
    wire [15:0] w54_n     = (quo_q > CYL_CAP) ? 16'hFFFF : quo_q[15:0];
    wire [31:0] w5857_n   = 32'(w54_n * w55_q[4:0] * w56_q[7:0]);
    wire        is_media  = (wbyte == CMD_READ) || (wbyte == CMD_WRITE)
                            || (wbyte == CMD_VERIFY);

    // Command decision; every command passes S_DONE so busy spans it
    always_comb begin
        state_d = state_q;
        res_d   = res_q;
        unique case (state_q)
            S_IDLE: begin
                if (cmd_go) begin
                    res_d   = '0;
                    state_d = S_DONE;
                    unique case (wbyte)
                        // No ready check here: the command is always taken
                        CMD_INIT_GEOM: begin
                            if (fault_s) res_d.abort_bit = 1'b1;
                            else if (spt_ok) state_d = S_DIVIDE;
                            else res_d.abort_bit = 1'b1;
                        end
                        CMD_EJECT: begin
                            if (!media_s) res_d.nm = 1'b1;
                            else if (fault_s) res_d.abort_bit = 1'b1;
                            else state_d = S_SPIN;
                        end
                        CMD_LOCK: begin
                            if (!media_s) res_d.nm = 1'b1;
                            else if (lock_q && mcr_q) res_d.media_change_request = 1'b1;
                        end
                        CMD_READ, CMD_WRITE, CMD_VERIFY: begin
                            if (!geom_ok_q) res_d.idnf = 1'b1;
                            else res_d.abort_bit = 1'b1;
                        end
                        default: res_d.abort_bit = 1'b1;
                    endcase
                end
            end
            S_DIVIDE: if (div_cnt_q == 5'h00) state_d = S_DONE;
            S_SPIN:   if (spun_s) state_d = S_EJECT;
            S_EJECT:  state_d = S_DONE;
            S_DONE:   state_d = S_IDLE;
            default:  state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            state_q <= S_IDLE;
            res_q   <= '0;
        end else begin
            state_q <= state_d;
            res_q   <= res_d;
        end
    end

    // Restoring divider: one quotient bit per cycle, 24 cycles
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            rem_q     <= '0;
            quo_q     <= '0;
            divisor_q <= '0;
            div_cnt_q <= '0;
        end else if (state_q == S_IDLE && state_d == S_DIVIDE) begin
            rem_q     <= '0;
            quo_q     <= CAP_DIVIDEND;
            divisor_q <= divisor_n;
            div_cnt_q <= DIV_STEPS;
        end else if (state_q == S_DIVIDE && div_cnt_q != 5'h00) begin
            rem_q     <= trial[13] ? {rem_q[11:0], quo_q[23]} : trial[12:0];
            quo_q     <= {quo_q[22:0], ~trial[13]};
            div_cnt_q <= div_cnt_q - 5'h01;
        end
    end

    // Identify geometry words; words 1,3,6,61:60 are constants
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            geom_ok_q <= 1'b1;
            w54_q     <= DEF_CYL;
            w55_q     <= DEF_HEADS;
            w56_q     <= DEF_SPT;
            w5857_q   <= RST_W5857;
        end else if (state_q == S_IDLE && state_d == S_DIVIDE) begin
            w55_q <= {11'h000, new_heads};
            w56_q <= {8'h00, new_spt};
        end else if (state_q == S_DIVIDE && state_d == S_DONE) begin
            geom_ok_q <= 1'b1;
            w54_q     <= w54_n;
            w5857_q   <= w5857_n;
        end else if (cmd_go && wbyte == CMD_INIT_GEOM && !spt_ok) begin
            // Stale geometry zeroed so nobody trusts it
            geom_ok_q <= 1'b0;
            w54_q     <= '0;
            w55_q     <= '0;
            w56_q     <= '0;
            w5857_q   <= '0;
        end
    end

    // Single lock level: one bit, no count; dropped as the eject launches
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            lock_q <= 1'b0;
        end else if (state_d == S_EJECT) begin
            lock_q <= 1'b0;
        end else if (state_q == S_DONE && cmd_q == CMD_LOCK && !res_q.nm) begin
            lock_q <= 1'b1;
        end
    end

    // Change request memory; set by a press while locked, cleared once unlocked
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            mcr_q <= 1'b0;
        end else if (button_up && lock_q) begin
            mcr_q <= 1'b1;
        end else if (!lock_q) begin
            mcr_q <= 1'b0;
        end
    end

    // Spin-down request and one-cycle eject pulse
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            spindle_stop_out <= 1'b0;
            eject_out        <= 1'b0;
        end else begin
            spindle_stop_out <= (state_d == S_SPIN) || (state_d == S_EJECT);
            eject_out        <= (state_d == S_EJECT);
        end
    end
    assign lock_out = lock_q;

    // Fault at completion turns the command into an abort
    wire             fin_fault = fault_s;
    chstm_error_type fin_err;
    always_comb begin
        fin_err      = res_q;
        fin_err.abort_bit = res_q.abort_bit | fin_fault;
    end
    wire fin_bad = |fin_err;

    // Status and error outputs; busy ends only with results in place
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            status_q <= '0;
            err_q    <= '0;
        end else begin
            status_q.data_request_flag   <= 1'b0;
            status_q.rsv4  <= 1'b0;
            status_q.rsv21 <= 2'b00;
            if (cmd_go) begin
                status_q.busy <= 1'b1;
            end else if (state_q == S_DONE) begin
                status_q.busy  <= 1'b0;
                status_q.fault <= fin_fault;
                status_q.err   <= fin_bad;
                err_q          <= fin_err;
                if (cmd_q == CMD_EJECT && !fin_bad) status_q.drive_ready <= 1'b1;
            end else if (!busy && button_up && lock_q) begin
                err_q.media_change_request    <= 1'b1;
                status_q.err <= 1'b1;
            end
            if (ready_up) status_q.drive_ready <= 1'b1;
            else if (ready_dn && !(state_q == S_DONE && cmd_q == CMD_EJECT)) begin
                status_q.drive_ready <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    AST_NO_DRQ: assert property (!status_q.data_request_flag)
        else $error("data request raised by a non-data command");
    AST_BUSY_ON_CMD: assert property (cmd_go |=> status_q.busy)
        else $error("busy not set after command write");
    AST_BUSY_TILL_DONE: assert property (status_q.busy && state_q != S_DONE |=> status_q.busy)
        else $error("busy dropped before completion");
    AST_SUCCESS_CLEAN: assert property (state_q == S_DONE && !fin_bad
        |=> !status_q.busy && !status_q.err && !status_q.fault && !status_q.data_request_flag)
        else $error("clean completion left flags set");
    AST_ERR_FLAG: assert property (state_q == S_DONE && fin_bad
        |=> status_q.err && !status_q.busy)
        else $error("error completion without error flag");
    AST_BAD_GEOM: assert property (cmd_go && wbyte == CMD_INIT_GEOM && !spt_ok
        |=> !geom_ok_q ##1 err_q.abort_bit && !status_q.busy)
        else $error("unsupported geometry not aborted");
    AST_IDNF: assert property (cmd_go && is_media && !geom_ok_q
        |=> ##1 err_q.idnf)
        else $error("media access without ID-not-found");
    AST_GEOM_WORDS: assert property (state_q == S_IDLE && state_d == S_DIVIDE
        |=> w55_q == 16'({1'b0, $past(devhead_q[HEAD_MSB:0])} + 5'h01)
            && w56_q == 16'($past(seccnt_q)))
        else $error("geometry words not loaded");
    AST_DIV_LEN: assert property (state_q == S_IDLE && state_d == S_DIVIDE
        |=> ##24 state_q == S_DIVIDE ##1 state_q == S_DONE)
        else $error("divider length wrong");
    AST_PRODUCT: assert property (state_q == S_DONE && cmd_q == CMD_INIT_GEOM && !res_q.abort_bit
        |-> w5857_q == 32'(w54_q * w55_q[4:0] * w56_q[7:0]))
        else $error("capacity product mismatch");
    AST_EJECT_UNLOCK: assert property (eject_out |-> !lock_q)
        else $error("media ejected while still locked");
    AST_NM: assert property (cmd_go && wbyte == CMD_EJECT && !media_s
        |=> ##1 err_q.nm && status_q.err)
        else $error("eject without media lacks no_media");

    CVR_GEOM_OK: cover property (state_q == S_DIVIDE ##[1:30] state_q == S_DONE);
    CVR_EJECT: cover property (eject_out);
    CVR_LOCK_MCR: cover property (lock_q && button_up);
    CVR_BAD_GEOM: cover property (!geom_ok_q && cmd_go);

endmodule : chstm_core
`default_nettype wire

// ===== chstm_mech_model.sv
`timescale 1ns/1ps
`default_nettype none
module chstm_mech_model (
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    input  wire logic spindle_stop_in,
    input  wire logic eject_in,
    input  wire logic insert_in,
    output logic      media_present_out,
    output logic      spun_down_out
);
    logic [3:0] spin_cnt_q;

    // Spindle needs real time to stop, so eject cannot finish early
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in || !spindle_stop_in) spin_cnt_q <= 4'h0;
        else if (spin_cnt_q != 4'hF) spin_cnt_q <= spin_cnt_q + 4'h1;
    end
    assign spun_down_out = (spin_cnt_q == 4'hF);

    // Media leaves on the eject pulse and comes back only when inserted
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) media_present_out <= 1'b1;
        else if (eject_in) media_present_out <= 1'b0;
        else if (insert_in) media_present_out <= 1'b1;
    end
endmodule : chstm_mech_model
`default_nettype wire

// ===== chstm_pkg.sv
`default_nettype none
package chstm_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [7:0] OFS_FEATURE   = 8'h00;
    localparam logic [7:0] OFS_ERROR     = 8'h04;
    localparam logic [7:0] OFS_SECCNT    = 8'h08;
    localparam logic [7:0] OFS_SECNUM    = 8'h0C;
    localparam logic [7:0] OFS_CYL_LO    = 8'h10;
    localparam logic [7:0] OFS_CYL_HI    = 8'h14;
    localparam logic [7:0] OFS_DEVHEAD   = 8'h18;
    localparam logic [7:0] OFS_STATUS    = 8'h1C;
    localparam logic [7:0] OFS_COMMAND   = 8'h20;
    localparam logic [7:0] OFS_ID_W1     = 8'h40;
    localparam logic [7:0] OFS_ID_W3     = 8'h44;
    localparam logic [7:0] OFS_ID_W6     = 8'h48;
    localparam logic [7:0] OFS_ID_W53    = 8'h4C;
    localparam logic [7:0] OFS_ID_W54    = 8'h50;
    localparam logic [7:0] OFS_ID_W55    = 8'h54;
    localparam logic [7:0] OFS_ID_W56    = 8'h58;
    localparam logic [7:0] OFS_ID_W5857  = 8'h5C;
    localparam logic [7:0] OFS_ID_W6160  = 8'h60;

    // Command codes
    localparam logic [7:0] CMD_INIT_GEOM = 8'h91;
    localparam logic [7:0] CMD_EJECT     = 8'hED;
    localparam logic [7:0] CMD_LOCK      = 8'hDE;
    localparam logic [7:0] CMD_READ      = 8'h20;
    localparam logic [7:0] CMD_WRITE     = 8'h30;
    localparam logic [7:0] CMD_VERIFY    = 8'h40;

    // Field positions
    localparam int DEVSEL_BIT   = 4;
    localparam int HEAD_MSB     = 3;

    // Capacity and default geometry (plain defaults, not a real part)
    localparam logic [31:0] CAPACITY_SECTORS = 32'h000F_C000;
    localparam logic [15:0] DEF_CYL          = 16'h0400;
    localparam logic [15:0] DEF_HEADS        = 16'h0010;
    localparam logic [15:0] DEF_SPT          = 16'h003F;
    localparam logic [23:0] CAP_LIMIT        = 24'hFB_FC10;
    localparam logic [23:0] CAP_DIVIDEND     =
        (CAPACITY_SECTORS > {8'h00, CAP_LIMIT}) ? CAP_LIMIT : CAPACITY_SECTORS[23:0];
    localparam logic [23:0] CYL_CAP          = 24'h00_FFFF;
    localparam logic [7:0]  SPT_MAX          = 8'h3F;
    localparam logic [4:0]  DIV_STEPS        = 5'h18;

    // Reset values
    localparam logic [31:0] RST_W5857 = 32'h000F_C000;
    localparam logic [7:0]  RST_BYTE  = 8'h00;

    typedef struct packed {
        logic       busy;
        logic       drive_ready;
        logic       fault;
        logic       rsv4;
        logic       data_request_flag;
        logic [1:0] rsv21;
        logic       err;
    } chstm_status_type;

    typedef struct packed {
        logic [1:0] rsv76;
        logic       idnf;
        logic       media_change_request;
        logic       abort_bit;
        logic       nm;
        logic       obs0;
    } chstm_error_type;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } chstm_avl_req_type;

endpackage : chstm_pkg
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import chstm_pkg::*;
    chstm_avl_req_type req;
    logic [31:0]       rdata, v;
    logic              clk, rstn, wreq, rdy, btn, flt, spin, spun, ej, lck, media, ins;
    logic              saw_stop, saw_ej;
    int                fails, cmp_count, q, hd, sp;

    chstm_core u_chstm_core (.sys_clk_in(clk), .rstn_in(rstn), .avl_req_in(req),
        .avl_readdata_out(rdata), .avl_waitrequest_out(wreq), .ready_in(rdy),
        .media_present_in(media), .change_button_in(btn), .fault_in(flt),
        .spun_down_in(spun), .spindle_stop_out(spin), .eject_out(ej), .lock_out(lck));
    chstm_mech_model u_chstm_mech_model (.sys_clk_in(clk), .rstn_in(rstn),
        .spindle_stop_in(spin), .eject_in(ej), .insert_in(ins),
        .media_present_out(media), .spun_down_out(spun));

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Remember spin-down and eject activity for the eject check
    always @(posedge clk) begin
        saw_stop <= rstn & (saw_stop | spin);
        saw_ej   <= rstn & (saw_ej | ej);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Waitrequest and read data are taken at the rising edge, before it updates them
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}, byteenable: 4'hF};
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        v = rdata;
        req <= '0;
        @(posedge clk);
    endtask : xfer

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00);
        check(v, exp);
    endtask : rchk

    task automatic poll;
        int n;
        n = 0;
        do begin
            xfer(1'b0, OFS_STATUS, 8'h00);
            n++;
        end while (v[7] !== 1'b0 && n < 100);
        // A command that never leaves busy counts against the run
        if (v[7] !== 1'b0) fails++;
    endtask : poll

    task automatic cmd(input logic [7:0] c);
        xfer(1'b1, OFS_COMMAND, c);
        poll();
    endtask : cmd

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    // Watchdog well beyond the expected run length
    initial begin
        #(25 * 20000);
        fails++;
        test_done();
    end

    initial begin
        req = '0;
        {rstn, btn, flt, ins} = 4'h0;
        rdy = 1'b1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rchk(OFS_STATUS, 32'h40);
        rchk(OFS_ERROR, 32'h00);
        rchk(8'h7C, 32'h00);
        $display("Test 1 reset done");
        // Valid translations with drive ready low; second one hits the cap
        rdy <= 1'b0;
        repeat (5) @(posedge clk);
        for (int i = 0; i < 2; i++) begin
            sp = (i == 0) ? 32 : 1;
            hd = (i == 0) ? 7 : 0;
            q = CAP_DIVIDEND / ((hd + 1) * sp);
            if (q > 65535) q = 65535;
            xfer(1'b1, OFS_SECCNT, 8'(sp));
            xfer(1'b1, OFS_DEVHEAD, 8'h10 | 8'(hd));
            cmd(CMD_INIT_GEOM);
            check(v, 32'h00);
            rchk(OFS_ID_W55, 32'(hd + 1));
            rchk(OFS_ID_W56, 32'(sp));
            rchk(OFS_ID_W54, 32'(q));
            rchk(OFS_ID_W5857, 32'(q * (hd + 1) * sp));
        end
        rchk(OFS_ID_W1, {16'h0, DEF_CYL});
        rchk(OFS_ID_W3, {16'h0, DEF_HEADS});
        rchk(OFS_ID_W6, {16'h0, DEF_SPT});
        rchk(OFS_ID_W6160, CAPACITY_SECTORS);
        rchk(OFS_DEVHEAD, 32'h10);
        $display("Test 2 translation done");
        // Unsupported translation, then media access until repaired
        rdy <= 1'b1;
        xfer(1'b1, OFS_SECCNT, 8'h00);
        cmd(CMD_INIT_GEOM);
        check(v, 32'h41);
        rchk(OFS_ERROR, 32'h04);
        xfer(1'b0, OFS_ID_W53, 8'h00);
        check(32'(v[0]), 32'h0);
        // A code the block does not serve ends as aborted
        cmd(8'hE5);
        check(v, 32'h41);
        rchk(OFS_ERROR, 32'h04);
        cmd(CMD_READ);
        rchk(OFS_ERROR, 32'h10);
        cmd(CMD_WRITE);
        rchk(OFS_ERROR, 32'h10);
        cmd(CMD_VERIFY);
        rchk(OFS_ERROR, 32'h10);
        xfer(1'b1, OFS_SECCNT, 8'h3F);
        xfer(1'b1, OFS_COMMAND, CMD_INIT_GEOM);
        xfer(1'b0, OFS_STATUS, 8'h00);
        check(32'(v[7]), 32'h1);
        xfer(1'b1, OFS_SECCNT, 8'h05);
        poll();
        check(v, 32'h40);
        rchk(OFS_SECCNT, 32'h3F);
        cmd(CMD_READ);
        rchk(OFS_ERROR, 32'h04);
        $display("Test 3 invalid translation done");
        // Single-level lock, then a change request while locked
        cmd(CMD_LOCK);
        check(32'({v[7:0], 7'h0, lck}), 32'h4001);
        cmd(CMD_LOCK);
        check(v, 32'h40);
        btn <= 1'b1;
        repeat (6) @(posedge clk);
        btn <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(OFS_STATUS, 32'h41);
        rchk(OFS_ERROR, 32'h08);
        cmd(CMD_LOCK);
        check(v, 32'h41);
        rchk(OFS_ERROR, 32'h08);
        $display("Test 4 lock done");
        // Eject issued only with drive ready high
        cmd(CMD_EJECT);
        check(v, 32'h40);
        check(32'({lck, media, saw_stop, saw_ej}), 32'h3);
        cmd(CMD_EJECT);
        check(v, 32'h41);
        rchk(OFS_ERROR, 32'h02);
        ins <= 1'b1;
        flt <= 1'b1;
        @(posedge clk);
        ins <= 1'b0;
        repeat (5) @(posedge clk);
        cmd(CMD_LOCK);
        check(v, 32'h61);
        xfer(1'b0, OFS_ERROR, 8'h00);
        check(v & 32'h04, 32'h04);
        flt <= 1'b0;
        $display("Test 5 eject and fault done");
        test_done();
    end
endmodule : tb
`default_nettype wire
